// ===== hw/qrx_top.sv
// four-channel receive path: loopback select, comma alignment, recovered clocks
// assumes clk runs at one serial bit time; serial inputs are asynchronous pins,
// the transmit bits come from logic on clk
`timescale 1ns/1ps
`include "qrx_defs.svh"

// What this block does
// R1 - present 10-bit characters, timed by recovered clocks
// R2 - bit zero holds earliest received bit
// R3 - rate pin low 1/20, high 1/10
// R4 - two complementary clocks, synchronous to bus
// R5 - loopback low: take external serial input
// R6 - loopback high: take own transmit stream
// R7 - sync high: align and flag commas
// R8 - sync low: hold boundary, flag low
// R9 - flag on comma, seven fixed bits; in slow mode only on the true rise
// R10 - flag lasts half a comp period
// R11 - flag rises only with true clock
// R12 - loopback high: output true high, comp low
// R13 - realign so comma fills one word
// R14 - far side samples with recovered clocks
module qrx_top #(
  parameter int CH    = `QRX_CHANNELS,
  parameter int DEPTH = `QRX_FIFO_DEPTH
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              rec_clk_rate_sel,
  input  wire logic                              loopback_en,
  input  wire logic                              sync_en,
  input  wire logic                              present_hold,
  input  wire logic [CH-1:0]                     serial_rx_in,
  input  wire logic [CH-1:0]                     serial_tx_bit,
  output logic      [CH-1:0]                     serial_tx_out_p,
  output logic      [CH-1:0]                     serial_tx_out_n,
  output logic      [CH-1:0][`QRX_WORD_BITS-1:0] rx_char_bus,
  output logic      [CH-1:0]                     rec_clk_true,
  output logic      [CH-1:0]                     rec_clk_comp,
  output logic      [CH-1:0]                     comma_flag,
  output logic      [CH-1:0]                     fifo_in_ready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // comma test: last three bits are don't care
  function automatic logic is_comma(input qrx_pkg::qrx_char_t w);
    is_comma = ((w & `QRX_COMMA_MASK) == `QRX_COMMA_VALUE);
  endfunction : is_comma

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic          rst_a_q;     // first reset stage
  logic          rst_n;       // released reset used everywhere
  logic [2:0]    ctl_a_q;     // first stage of shared pins
  logic [2:0]    ctl_q;       // synchronised shared pins
  logic [CH-1:0] rxs_a_q;     // first stage of serial inputs
  logic [CH-1:0] rxs_q;       // synchronised serial inputs
  qrx_pkg::qrx_rate_t rate;   // decoded rate select

  // reset is asserted at once, released two edges later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  // two stages for the shared pins and serial inputs (present_hold is not synchronised); only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_a_q <= '0;
      ctl_q   <= '0;
      rxs_a_q <= '0;
      rxs_q   <= '0;
    end else begin
      ctl_a_q <= {sync_en, loopback_en, rec_clk_rate_sel};
      ctl_q   <= ctl_a_q;
      rxs_a_q <= serial_rx_in;
      rxs_q   <= rxs_a_q;
    end
  end

  // R3 rate decode
  assign rate = ctl_q[0] ? qrx_pkg::qrx_rate_fast : qrx_pkg::qrx_rate_slow;

  // ----------------------------------------------------------------
  // per-channel datapath
  // ----------------------------------------------------------------
  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic [`QRX_SHIFT_BITS-1:0] sr_q;        // serial history, oldest at bit 0
    logic [3:0]                 bit_q;       // bit position inside a character
    logic                       push_q;      // character ready for the fifo
    qrx_pkg::qrx_char_t         word_q;      // character held for the fifo
    logic                       serial_bit;  // selected serial source
    qrx_pkg::qrx_char_t         newest;      // last ten bits received
    logic                       realign;     // comma found off the boundary
    logic [`QRX_DIV_W-1:0]      div_q;       // recovered clock phase
    logic [`QRX_DIV_W-1:0]      div_d;       // next phase
    logic [`QRX_DIV_W-1:0]      top;         // last phase of a period
    logic [`QRX_DIV_W-1:0]      half;        // first low phase
    logic                       pop_req;     // fetch next character now
    logic                       popped_q;    // fifo gave a character
    logic                       out_valid;   // fifo has a character
    qrx_pkg::qrx_char_t         fifo_data;   // registered fifo output
    logic                       in_ready;    // fifo has room
    logic                       tx_p_q;      // serial output true leg
    logic                       tx_n_q;      // serial output comp leg
    qrx_pkg::qrx_char_t         char_q;      // presented character
    logic                       rck_q;       // true recovered clock
    logic                       rckn_q;      // comp recovered clock
    logic                       flag_q;      // comma flag
    logic                       fin_rdy_q;   // registered fifo room

    // R5 external input when loopback is low
    // R6 own transmit stream when loopback is high
    assign serial_bit = ctl_q[1] ? serial_tx_bit[i] : rxs_q[i];
    assign newest     = sr_q[`QRX_SHIFT_BITS-1 -: `QRX_WORD_BITS];
    // R7 align only while sync is on; R8 otherwise the boundary stays
    assign realign    = ctl_q[2] && is_comma(newest) && (bit_q != `QRX_BIT_TOP);

    // R12 static output during loopback, true leg high
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_p_q <= 1'b1;
        tx_n_q <= 1'b0;
      end else begin
        tx_p_q <= ctl_q[1] | serial_tx_bit[i];
        tx_n_q <= ~ctl_q[1] & ~serial_tx_bit[i];
      end
    end

    // R2 new bits enter at the top and move down, so bit 0 is earliest
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sr_q <= '0;
      end else begin
        sr_q <= {serial_bit, sr_q[`QRX_SHIFT_BITS-1:1]};
      end
    end

    // character boundary counter
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        bit_q  <= '0;
        push_q <= 1'b0;
        word_q <= '0;
      end else begin
        push_q <= 1'b0;
        // R13 comma off boundary closes the word here
        if (realign || bit_q == `QRX_BIT_TOP) begin
          bit_q  <= '0;
          push_q <= 1'b1;
          word_q <= newest;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end
    end

    // the fifo absorbs the phase step a realignment causes;
    // a character offered while it is full is lost, shown on fifo_in_ready
    qrx_fifo #(
      .WIDTH (`QRX_WORD_BITS),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push_q),
      .in_data   (word_q),
      .in_ready  (in_ready),
      .out_valid (out_valid),
      .out_ready (pop_req),
      .out_data  (fifo_data)
    );

    // R3 divider limits follow the rate pin
    assign top  = (rate == qrx_pkg::qrx_rate_fast) ? `QRX_TOP_FAST : `QRX_TOP_SLOW;
    assign half = (rate == qrx_pkg::qrx_rate_fast) ? `QRX_HALF_FAST : `QRX_HALF_SLOW;
    assign div_d = (div_q >= top) ? '0 : div_q + 5'h01;
    // fetch one cycle before each clock edge that carries a character:
    // fast mode once a period (true rise only), slow mode on both edges,
    // so the drain rate matches one character per ten bits while present_hold is low
    assign pop_req = !present_hold &&
                     (div_d == '0 || (rate == qrx_pkg::qrx_rate_slow && div_d == half));

    // R4 both clocks from one phase counter, always complements
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        div_q  <= '0;
        rck_q  <= 1'b1;
        rckn_q <= 1'b0;
      end else begin
        div_q  <= div_d;
        rck_q  <= (div_d < half);
        rckn_q <= !(div_d < half);
      end
    end

    // remember whether the fetch found a character
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        popped_q  <= 1'b0;
        fin_rdy_q <= 1'b1;
      end else begin
        popped_q  <= pop_req && out_valid;
        fin_rdy_q <= in_ready;
      end
    end

    // R1 bus changes one bit time after each recovered clock edge that fetched a character
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        char_q <= '0;
      end else if (popped_q) begin
        char_q <= fifo_data;
      end
    end

    // comma flag; in slow mode a comma on the falling half is not flagged
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_q <= 1'b0;
      end else if (!ctl_q[2]) begin
        // R8 flag held low
        flag_q <= 1'b0;
      end else if (popped_q && div_q == '0) begin
        // R9 R11 raise only where the true clock rises
        flag_q <= is_comma(fifo_data);
      end else if (div_q == half) begin
        // R10 drop after half a comp period
        flag_q <= 1'b0;
      end
    end

    assign serial_tx_out_p[i] = tx_p_q;
    assign serial_tx_out_n[i] = tx_n_q;
    assign rx_char_bus[i]     = char_q;
    assign rec_clk_true[i]    = rck_q;
    assign rec_clk_comp[i]    = rckn_q;
    assign comma_flag[i]      = flag_q;
    assign fifo_in_ready[i]   = fin_rdy_q;
  end : g_ch
endmodule : qrx_top

// ===== shared/qrx_defs.svh
// constants for the quad receive word-align block
// assumes inclusion by bare name from the package and the design files
`ifndef QRX_DEFS_SVH
`define QRX_DEFS_SVH

// ----------------------------------------------------------------
// character layout
// ----------------------------------------------------------------
`define QRX_CHANNELS     4
`define QRX_WORD_BITS    10
`define QRX_SHIFT_BITS   20
// comma: first seven bits received are 0011111, bit 0 earliest
`define QRX_COMMA_MASK   10'h07F
`define QRX_COMMA_VALUE  10'h07C

// ----------------------------------------------------------------
// recovered clock divider, counted in serial bit times
// ----------------------------------------------------------------
`define QRX_DIV_W        5
`define QRX_TOP_FAST     5'h09
`define QRX_TOP_SLOW     5'h13
`define QRX_HALF_FAST    5'h05
`define QRX_HALF_SLOW    5'h0A
`define QRX_BIT_TOP      4'h9

// ----------------------------------------------------------------
// buffering
// ----------------------------------------------------------------
`define QRX_FIFO_DEPTH   16

`endif

// ===== shared/qrx_pkg.sv
// types shared by the quad receive word-align block
// assumes the constants header sits beside it on the include path
`include "qrx_defs.svh"

package qrx_pkg;
  // recovered clock rate as selected by the rate pin
  typedef enum logic {
    qrx_rate_slow,
    qrx_rate_fast
  } qrx_rate_t;

  // one received character
  typedef logic [`QRX_WORD_BITS-1:0] qrx_char_t;
endpackage : qrx_pkg

// ===== hw/qrx_fifo.sv
// small synchronous fifo with registered read data
// assumes one clock and an active-low reset already synchronised
`timescale 1ns/1ps

module qrx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];   // character store
  logic [AW-1:0]    wr_q;            // write pointer
  logic [AW-1:0]    rd_q;            // read pointer
  logic [AW:0]      count_q;         // words held
  logic             push;            // accepted write
  logic             pop;             // accepted read

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // full and empty are taken from the count, so they never lie
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);

  // write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // read data appears the cycle after the pop, from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (pop) begin
      out_data <= mem_q[rd_q];
    end
  end
endmodule : qrx_fifo

// ===== dv/qrx_top_monitor.sv
// checker for qrx_top: clock pair, comma flag and loopback pins
// assumes it is bound to qrx_top and sees only its ports
`timescale 1ns/1ps
`include "qrx_defs.svh"
module qrx_top_monitor #(
  parameter int CH = 4
) (
  input wire logic                              clk,
  input wire logic                              rstn,
  input wire logic                              rec_clk_rate_sel,
  input wire logic                              loopback_en,
  input wire logic                              sync_en,
  input wire logic [CH-1:0]                     serial_tx_out_p,
  input wire logic [CH-1:0]                     serial_tx_out_n,
  input wire logic [CH-1:0][`QRX_WORD_BITS-1:0] rx_char_bus,
  input wire logic [CH-1:0]                     rec_clk_true,
  input wire logic [CH-1:0]                     rec_clk_comp,
  input wire logic [CH-1:0]                     comma_flag
);
  logic       rate_q; // rate pin one edge ago
  logic [5:0] stab_q; // edges since rate pin last moved
  logic       ck_q;   // true clock one edge ago
  logic [4:0] run_q;  // samples the true clock has held its level
  // ----------------------------------------
  // run length of each true clock level, checked at its edges
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck_q  <= 1'b1;
      run_q <= 5'h00;
    end else begin
      ck_q <= rec_clk_true[0];
      if (ck_q != rec_clk_true[0]) run_q <= 5'h01;
      else if (run_q != 5'h1F) run_q <= run_q + 5'h01;
    end
  end
  // ----------------------------------------
  // rate settle counter: pin passes a synchroniser, so wait it out
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_q <= 1'b0;
      stab_q <= 6'h00;
    end else begin
      rate_q <= rec_clk_rate_sel;
      if (rate_q != rec_clk_rate_sel) stab_q <= 6'h00;
      else if (stab_q != 6'h3F) stab_q <= stab_q + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_comp; rec_clk_comp == ~rec_clk_true; endproperty
  // looks back at the level just ended, so a rate change cannot cut a check
  property p_fast;
    $changed(rec_clk_true[0]) && rec_clk_rate_sel && stab_q > 6'h28 |-> run_q == 5'h05;
  endproperty
  property p_slow;
    $changed(rec_clk_true[0]) && !rec_clk_rate_sel && stab_q > 6'h28 |-> run_q == 5'h0A;
  endproperty
  property p_match;
    comma_flag[0] |-> (rx_char_bus[0] & `QRX_COMMA_MASK) == `QRX_COMMA_VALUE;
  endproperty
  property p_rise;
    $rose(comma_flag[0]) |-> rec_clk_true[0] && !$past(rec_clk_true[0], 3);
  endproperty
  property p_fall; $fell(rec_clk_true[0]) |-> ##[0:2] !comma_flag[0]; endproperty
  property p_off; !sync_en[*8] ##1 !sync_en[*8] |-> comma_flag == '0; endproperty
  property p_loop;
    loopback_en[*5] |-> serial_tx_out_p == '1 && serial_tx_out_n == '0;
  endproperty
  property p_pair; serial_tx_out_n == ~serial_tx_out_p; endproperty
  a_comp: assert property (p_comp) else $error("clock pair not complementary");
  a_fast: assert property (p_fast) else $error("fast clock period wrong");
  a_slow: assert property (p_slow) else $error("slow clock period wrong");
  a_match: assert property (p_match) else $error("flag without comma");
  a_rise: assert property (p_rise) else $error("flag off true rise");
  a_fall: assert property (p_fall) else $error("flag outlives half period");
  a_off: assert property (p_off) else $error("flag while sync off");
  a_loop: assert property (p_loop) else $error("serial out not parked");
  a_pair: assert property (p_pair) else $error("serial out legs equal");
  c_flag: cover property ($rose(comma_flag[0]));
  c_loop: cover property (loopback_en && $rose(comma_flag[0]));
  c_slow: cover property (!rec_clk_rate_sel && $rose(comma_flag[0]));
endmodule : qrx_top_monitor

bind qrx_top qrx_top_monitor #(.CH(CH)) u_mon (
  .clk(clk), .rstn(rstn), .rec_clk_rate_sel(rec_clk_rate_sel),
  .loopback_en(loopback_en), .sync_en(sync_en), .serial_tx_out_p(serial_tx_out_p),
  .serial_tx_out_n(serial_tx_out_n), .rx_char_bus(rx_char_bus),
  .rec_clk_true(rec_clk_true), .rec_clk_comp(rec_clk_comp), .comma_flag(comma_flag)
);

// ===== dv/qrx_pcs_model.sv
// far-side coding logic for one channel: logs one character per clock period
// assumes clk is the bit clock, so recovered clock edges are seen on it
`timescale 1ns/1ps
module qrx_pcs_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic [9:0] rx_char_bus,
  input  wire logic       rec_clk_true,
  input  wire logic       comma_flag,
  output logic            present_hold
);
  logic [10:0] log_q[$];    // {flag seen, character}
  logic        prev_q = 1'b1; // true clock one edge ago
  logic        seen_q = 1'b0; // flag seen in this high half
  // slow answers: the bench can hold presentation off
  assign present_hold = stall;
  always @(posedge clk) begin
    prev_q <= rec_clk_true;
    if (prev_q && !rec_clk_true) begin
      log_q.push_back({seen_q | comma_flag, rx_char_bus});
      seen_q <= 1'b0;
    end else if (rec_clk_true) seen_q <= seen_q | comma_flag;
  end
endmodule : qrx_pcs_model

// ===== dv/test_qrx_top.sv
// bench for qrx_top: serial streams in, characters logged by the far side
// assumes the far-side model watches channel 0; all lanes get one stream
`timescale 1ns/1ps
module test_qrx_top;
  localparam logic [9:0] FILL  = 10'h155; // alternating, never a comma
  localparam logic [9:0] COMMA = 10'h17C; // 0011111 then 010
  localparam logic [9:0] D1    = 10'h0F3;
  localparam logic [9:0] D2    = 10'h31C;
  logic            clk = 1'b0;
  logic            rstn, rate, loop, sync, stall, hold;
  logic [3:0]      rxin, txb, tx_p, tx_n, rck, rckn, flag, rdy;
  logic [3:0][9:0] bus;
  logic [9:0]      held;
  int              fail_count = 0;
  int              check_count = 0;
  int              idx;
  always #2.5 clk = ~clk;
  qrx_top u_dut (.clk(clk), .rstn(rstn), .rec_clk_rate_sel(rate), .loopback_en(loop),
    .sync_en(sync), .present_hold(hold), .serial_rx_in(rxin), .serial_tx_bit(txb),
    .serial_tx_out_p(tx_p), .serial_tx_out_n(tx_n), .rx_char_bus(bus),
    .rec_clk_true(rck), .rec_clk_comp(rckn), .comma_flag(flag), .fifo_in_ready(rdy));
  qrx_pcs_model u_pcs (.clk(clk), .stall(stall), .rx_char_bus(bus[0]),
    .rec_clk_true(rck[0]), .comma_flag(flag[0]), .present_hold(hold));
  task automatic check(input string name, input logic [39:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // earliest bit first; the unused path idles high
  task automatic send(input logic [9:0] c, input int n = 10);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxin = loop ? 4'hF : {4{c[i]}};
      txb = loop ? {4{c[i]}} : 4'hF;
    end
  endtask : send
  task automatic fill(input int k);
    repeat (k) send(FILL);
  endtask : fill
  function automatic int hits(input logic [10:0] v);
    hits = 0;
    foreach (u_pcs.log_q[i]) if (u_pcs.log_q[i] === v) hits++;
  endfunction : hits
  // comma three bits off the boundary, then two data characters
  task automatic align(input logic lb);
    loop = lb;
    fill(4);
    u_pcs.log_q.delete();
    send(FILL, 3);
    send(COMMA);
    send(D1);
    send(D2);
    fill(9);
    idx = 0;
    while (idx < u_pcs.log_q.size() - 1 && !u_pcs.log_q[idx][10]) idx++;
    check("comma", u_pcs.log_q[idx], {1'b1, COMMA});
    check("first", u_pcs.log_q[idx + 1], {1'b0, D1});
    check("second", u_pcs.log_q[idx + 2], {1'b0, D2});
    check("lanes", {bus[1], bus[2], bus[3]}, {3{bus[0]}});
  endtask : align
  initial begin
    #60000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rstn, loop, stall} = 3'h0;
    {rate, sync} = 2'h3;
    {rxin, txb} = 8'hFF;
    repeat (20) @(negedge clk);
    check("reset", {rck, rckn, flag, tx_p, tx_n, rdy}, 24'hF00F0F);
    check("rbus", bus, 40'h0);
    rstn = 1'b1;
    align(1'b0);
    align(1'b1);
    check("loop", {tx_p, tx_n}, 8'hF0);
    loop = 1'b0;
    u_pcs.log_q.delete();
    send(COMMA);
    send(D1);
    fill(4);
    sync = 1'b0;
    fill(2);
    send(FILL, 3);
    send(COMMA);
    send(D2);
    send(FILL, 7);
    send(COMMA);
    fill(8);
    check("flagged", hits({1'b1, COMMA}), 1);
    check("heldcomma", hits({1'b0, COMMA}), 1);
    check("heldd2", hits({1'b0, D2}), 0);
    sync = 1'b1;
    rate = 1'b0;
    fill(6);
    u_pcs.log_q.delete();
    send(FILL, 3);
    send(COMMA);
    send(COMMA);
    fill(10);
    check("slow", hits({1'b1, COMMA}), 1);
    stall = 1'b1;
    fill(2);
    held = bus[0];
    fill(20);
    check("full", rdy, 4'h0);
    check("stall", bus[0], held);
    stall = 1'b0;
    idx = 0;
    while (rdy[0] !== 1'b1 && idx < 100) begin
      @(negedge clk);
      idx++;
    end
    check("drain", rdy[0], 1'b1);
    report_and_stop();
  end
endmodule : test_qrx_top
